// file: inc/sbs_pkg.sv
// Shared constants and types for the serial bus status and reset block
package sbs_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CONTROL_REG_2 = 8'h00;
	localparam logic [7:0] OFF_BUS_STATUS_REG = 8'h04;
	localparam logic [7:0] OFF_DATA_BUFFER_REG = 8'h08;
	localparam logic [7:0] OFF_OWN_ADDRESS_REG = 8'h0C;
	localparam logic [7:0] OFF_BAUD_RATE_REG = 8'h10;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CR2_I2C_MODE = 0;
	localparam int CR2_MASTER = 1;
	localparam int CR2_SOFT_RESET_FIELD_LO = 4;
	localparam int SR_AAS = 0;
	localparam int SR_GC = 1;
	localparam int SR_LRB = 2;
	localparam int SR_IRQ = 3;
	localparam int SR_BUSY = 4;
	localparam int SR_RX_FULL = 5;
	localparam int OAR_ALS = 0;
	localparam int OAR_ADDR_LO = 1;
	localparam int BR_IDLE_RUN = 0;

	// ----------------------------------------------------------------
	// Reset values and codes
	// ----------------------------------------------------------------
	localparam logic [1:0] SOFT_RESET_FIELD_RESET = 2'h0;
	localparam logic [1:0] SOFT_RESET_FIELD_ARM = 2'h2;
	localparam logic [1:0] SOFT_RESET_FIELD_FIRE = 2'h1;
	localparam logic [6:0] OWN_ADDR_RESET = 7'h00;
	localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Timing counts (a half bit lasts HALF_BIT_CYCLES + 1 link clock cycles when mastering)
	// ----------------------------------------------------------------
	localparam logic [3:0] HALF_BIT_CYCLES = 4'h4;
	localparam logic [3:0] BITS_PER_FRAME = 4'h9;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic start;
		logic stop;
		logic rx_byte;
		logic ack_done;
	} sbs_evt_t;

	typedef struct packed {
		logic [7:0] data;
		logic first;
	} sbs_rx_t;

	typedef enum logic [4:0] {
		L_IDLE = 5'b00001,
		L_START = 5'b00010,
		L_LOW = 5'b00100,
		L_HIGH = 5'b01000,
		L_HOLD = 5'b10000
	} sbs_lstate_t;

endpackage

// file: hw/sbs_bus_status.sv
// Serial bus status monitors, data buffer side effects and soft reset
`timescale 1ns/1ps

// What this block does
// (RQ1) Address match sets addressed-as-slave flag
// (RQ2) Address-less mode: any byte after the first sets flag
// (RQ3) Data buffer access clears addressed flag
// (RQ4) All-zero first byte sets general call
// (RQ5) Start or stop clears general call
// (RQ6) Last bit follows SDA at SCL rise
// (RQ7) After irq, last bit holds ACK
// (RQ8) Buffer read fetches, write transmits in master mode
// (RQ9) Master write of address generates start
// (RQ10) Idle-run bit gates operation in idle
// (RQ11) Software sets idle-run before standby
// (RQ12) Writes 10 then 01 reset interface
// (RQ13) Soft reset restores all registers, flags
// (RQ14) Reset field clears itself after reset
// (RQ15) Soft reset returns to port mode
// (RQ16) Other value after 10 aborts sequence
module sbs_bus_status #(
	parameter int ADDR_W = 8
)(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic link_clk_i,
	input wire logic idle_i,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic scl_oe_n_o,
	output logic sda_o,
	output logic sda_oe_n_o
);
	// The decoder reads the low byte of the address
	if (ADDR_W < 8 || ADDR_W > 32)
	begin : g_bad_addr_w
		$error("ADDR_W out of range");
	end

	function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
		logic [7:0] o;
		o = a[7:0];
		case (o)
			sbs_pkg::OFF_CONTROL_REG_2: reg_index = 3'h1;
			sbs_pkg::OFF_BUS_STATUS_REG: reg_index = 3'h2;
			sbs_pkg::OFF_DATA_BUFFER_REG: reg_index = 3'h3;
			sbs_pkg::OFF_OWN_ADDRESS_REG: reg_index = 3'h4;
			sbs_pkg::OFF_BAUD_RATE_REG: reg_index = 3'h5;
			default: reg_index = 3'h0;
		endcase
		if ((a >> 8) != '0)
			reg_index = 3'h0;
	endfunction

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	logic aw_got_reg, w_got_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic wr_go, rd_go;
	logic [2:0] wr_idx, rd_idx;
	logic blk_rst;
	logic [31:0] rd_word;

	assign wr_go = aw_got_reg && w_got_reg && !s_axi_bvalid;
	assign wr_idx = reg_index(aw_addr_reg);
	assign rd_go = s_axi_arvalid && s_axi_arready;
	assign rd_idx = reg_index(s_axi_araddr);

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= sbs_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= !aw_got_reg && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_got_reg && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_idx == 3'h0 || wr_idx == 3'h2) ?
					sbs_pkg::RESP_SLVERR : sbs_pkg::RESP_OKAY;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= sbs_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !rd_go;
			if (rd_go)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= (rd_idx == 3'h0) ?
					sbs_pkg::RESP_SLVERR : sbs_pkg::RESP_OKAY;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	logic i2c_mode_reg, master_reg, als_reg, idle_run_reg;
	logic [1:0] soft_reset_field_field_reg;
	logic [6:0] own_addr_reg;
	logic [7:0] tx_data_reg;
	logic tx_tgl_reg;
	logic wr_ctl, wr_dbr, dbr_access;

	assign wr_ctl = wr_go && wr_idx == 3'h1 && w_strb_reg[0];
	assign wr_dbr = wr_go && wr_idx == 3'h3 && w_strb_reg[0];
	assign dbr_access = wr_dbr || (rd_go && rd_idx == 3'h3);

	always_ff @(posedge clk_i)
	begin
		if (blk_rst)
		begin
			i2c_mode_reg <= 1'b0; // [RQ13] [RQ15]
			master_reg <= 1'b0;
			soft_reset_field_field_reg <= sbs_pkg::SOFT_RESET_FIELD_RESET; // [RQ14]
			own_addr_reg <= sbs_pkg::OWN_ADDR_RESET;
			als_reg <= 1'b0;
			idle_run_reg <= 1'b0;
		end
		else if (wr_go && w_strb_reg[0])
		begin
			case (wr_idx)
				3'h1:
				begin
					i2c_mode_reg <= w_data_reg[sbs_pkg::CR2_I2C_MODE];
					master_reg <= w_data_reg[sbs_pkg::CR2_MASTER];
					soft_reset_field_field_reg <= w_data_reg[sbs_pkg::CR2_SOFT_RESET_FIELD_LO +: 2];
				end
				3'h4:
				begin
					als_reg <= w_data_reg[sbs_pkg::OAR_ALS];
					own_addr_reg <= w_data_reg[sbs_pkg::OAR_ADDR_LO +: 7];
				end
				3'h5: idle_run_reg <= w_data_reg[sbs_pkg::BR_IDLE_RUN];
				default: ;
			endcase
		end
	end

	// Writes to the buffer hand the byte to the link side by a toggle
	always_ff @(posedge clk_i)
	begin
		if (blk_rst)
		begin
			tx_data_reg <= 8'h00;
			tx_tgl_reg <= 1'b0;
		end
		else if (wr_dbr)
		begin
			tx_data_reg <= w_data_reg[7:0]; // [RQ8]
			tx_tgl_reg <= !tx_tgl_reg; // [RQ8] [RQ9]
		end
	end

	// ----------------------------------------------------------------
	// Two-write soft reset with handshake to the link domain
	// ----------------------------------------------------------------
	logic armed_reg, srst_req_reg, lrst_src_reg, blk_pulse_reg;
	logic [1:0] lrst_ack_sync;

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			armed_reg <= 1'b0;
			srst_req_reg <= 1'b0;
			blk_pulse_reg <= 1'b0;
		end
		else
		begin
			blk_pulse_reg <= 1'b0;
			if (wr_ctl)
			begin
				case (w_data_reg[sbs_pkg::CR2_SOFT_RESET_FIELD_LO +: 2])
					sbs_pkg::SOFT_RESET_FIELD_ARM: armed_reg <= 1'b1;
					sbs_pkg::SOFT_RESET_FIELD_FIRE:
					begin
						armed_reg <= 1'b0;
						if (armed_reg)
							srst_req_reg <= 1'b1; // [RQ12]
					end
					default: armed_reg <= 1'b0; // [RQ16]
				endcase
			end
			if (srst_req_reg && lrst_ack_sync[1])
			begin
				srst_req_reg <= 1'b0;
				blk_pulse_reg <= 1'b1; // [RQ12] [RQ13]
			end
		end
	end

	assign blk_rst = reset_i || blk_pulse_reg;

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			lrst_src_reg <= 1'b1;
		else
			lrst_src_reg <= srst_req_reg;
	end

	// ----------------------------------------------------------------
	// Link to system crossing
	// ----------------------------------------------------------------
	sbs_pkg::sbs_evt_t ev_tgl_reg;
	sbs_pkg::sbs_rx_t rx_hold_reg;
	logic lrb_reg, busy_reg, lrst_reg;
	logic [3:0] ev_s1, ev_s2, ev_s3;
	logic [1:0] lrb_sync, busy_sync;
	sbs_pkg::sbs_evt_t ev;

	always_ff @(posedge clk_i)
	begin
		if (blk_rst)
		begin
			ev_s1 <= 4'h0;
			ev_s2 <= 4'h0;
			ev_s3 <= 4'h0;
		end
		else
		begin
			ev_s1 <= ev_tgl_reg;
			ev_s2 <= ev_s1;
			ev_s3 <= ev_s2;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			lrb_sync <= 2'h0;
			busy_sync <= 2'h0;
			lrst_ack_sync <= 2'h0;
		end
		else
		begin
			lrb_sync <= {lrb_sync[0], lrb_reg};
			busy_sync <= {busy_sync[0], busy_reg};
			lrst_ack_sync <= {lrst_ack_sync[0], lrst_reg};
		end
	end

	assign ev = ev_s2 ^ ev_s3;

	// ----------------------------------------------------------------
	// Status flags; a set in the clearing cycle wins
	// ----------------------------------------------------------------
	logic aas_reg, gc_reg, irq_reg, rx_full_reg;
	logic [7:0] rx_data_reg;
	logic slave_on, addr_hit, aas_set, gc_set;

	assign slave_on = i2c_mode_reg && !master_reg;
	assign addr_hit = rx_hold_reg.data[7:1] == own_addr_reg ||
		rx_hold_reg.data == sbs_pkg::GEN_CALL_ADDR;
	assign aas_set = ev.rx_byte && slave_on &&
		((!als_reg && rx_hold_reg.first && addr_hit) || // [RQ1]
		(als_reg && !rx_hold_reg.first)); // [RQ2]
	assign gc_set = ev.rx_byte && slave_on && rx_hold_reg.first &&
		rx_hold_reg.data == sbs_pkg::GEN_CALL_ADDR; // [RQ4]

	always_ff @(posedge clk_i)
	begin
		if (blk_rst)
		begin
			aas_reg <= 1'b0;
			gc_reg <= 1'b0;
			irq_reg <= 1'b0;
			rx_full_reg <= 1'b0;
			rx_data_reg <= 8'h00;
		end
		else
		begin
			aas_reg <= aas_set || (aas_reg && !dbr_access); // [RQ3]
			gc_reg <= gc_set || (gc_reg && !ev.start && !ev.stop); // [RQ5]
			irq_reg <= ev.ack_done || (irq_reg && !dbr_access); // [RQ7]
			if (ev.rx_byte)
			begin
				rx_data_reg <= rx_hold_reg.data;
				rx_full_reg <= 1'b1;
			end
			else if (rd_go && rd_idx == 3'h3)
				rx_full_reg <= 1'b0; // [RQ8]
		end
	end

	always_comb
	begin
		rd_word = 32'h0000_0000;
		case (rd_idx)
			3'h1:
			begin
				rd_word[sbs_pkg::CR2_I2C_MODE] = i2c_mode_reg;
				rd_word[sbs_pkg::CR2_MASTER] = master_reg;
				rd_word[sbs_pkg::CR2_SOFT_RESET_FIELD_LO +: 2] = soft_reset_field_field_reg;
			end
			3'h2:
			begin
				rd_word[sbs_pkg::SR_AAS] = aas_reg;
				rd_word[sbs_pkg::SR_GC] = gc_reg;
				rd_word[sbs_pkg::SR_LRB] = lrb_sync[1]; // [RQ6] [RQ7]
				rd_word[sbs_pkg::SR_IRQ] = irq_reg;
				rd_word[sbs_pkg::SR_BUSY] = busy_sync[1];
				rd_word[sbs_pkg::SR_RX_FULL] = rx_full_reg;
			end
			3'h3: rd_word[7:0] = rx_data_reg; // [RQ8]
			3'h4:
			begin
				rd_word[sbs_pkg::OAR_ALS] = als_reg;
				rd_word[sbs_pkg::OAR_ADDR_LO +: 7] = own_addr_reg;
			end
			3'h5: rd_word[sbs_pkg::BR_IDLE_RUN] = idle_run_reg;
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// Halt level for the link: idle without the run bit stops the bus logic
	logic halt_reg;
	always_ff @(posedge clk_i)
	begin
		if (blk_rst)
			halt_reg <= 1'b0;
		else
			halt_reg <= idle_i && !idle_run_reg; // [RQ10]
	end

	// ----------------------------------------------------------------
	// Link domain: pin sampling, bus monitor and master start
	// ----------------------------------------------------------------
	logic [1:0] rst_l_sync, halt_l_sync, mst_l_sync, scl_sync, sda_sync;
	logic [2:0] tx_l_sync;
	logic scl_d, sda_d, scl_rise, start_det, stop_det, tx_req;
	logic [3:0] bit_cnt_reg, div_reg, mbit_reg;
	logic [7:0] shift_reg, mtx_reg;
	logic first_reg;
	sbs_pkg::sbs_lstate_t lstate_reg;

	always_ff @(posedge link_clk_i)
	begin
		rst_l_sync <= {rst_l_sync[0], lrst_src_reg};
		halt_l_sync <= {halt_l_sync[0], halt_reg};
		mst_l_sync <= {mst_l_sync[0], master_reg && i2c_mode_reg};
		tx_l_sync <= {tx_l_sync[1:0], tx_tgl_reg};
		scl_sync <= {scl_sync[0], scl_i};
		sda_sync <= {sda_sync[0], sda_i};
	end

	assign scl_rise = scl_sync[1] && !scl_d;
	assign start_det = scl_sync[1] && scl_d && sda_d && !sda_sync[1];
	assign stop_det = scl_sync[1] && scl_d && !sda_d && sda_sync[1];
	assign tx_req = tx_l_sync[2] ^ tx_l_sync[1];

	always_ff @(posedge link_clk_i)
	begin
		if (rst_l_sync[1])
		begin
			lrst_reg <= 1'b1;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			ev_tgl_reg <= '0;
			rx_hold_reg <= '0;
			lrb_reg <= 1'b0;
			busy_reg <= 1'b0;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			first_reg <= 1'b0;
		end
		else if (!halt_l_sync[1])
		begin
			lrst_reg <= 1'b0;
			scl_d <= scl_sync[1];
			sda_d <= sda_sync[1];
			if (start_det)
			begin
				ev_tgl_reg.start <= !ev_tgl_reg.start;
				busy_reg <= 1'b1;
				bit_cnt_reg <= 4'h0;
				first_reg <= 1'b1;
			end
			else if (stop_det)
			begin
				ev_tgl_reg.stop <= !ev_tgl_reg.stop;
				busy_reg <= 1'b0;
			end
			else if (scl_rise && busy_reg)
			begin
				lrb_reg <= sda_sync[1]; // [RQ6]
				if (bit_cnt_reg == sbs_pkg::BITS_PER_FRAME - 4'h1)
				begin
					bit_cnt_reg <= 4'h0;
					ev_tgl_reg.ack_done <= !ev_tgl_reg.ack_done; // [RQ7]
					first_reg <= 1'b0;
				end
				else
				begin
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
					shift_reg <= {shift_reg[6:0], sda_sync[1]};
				end
				if (bit_cnt_reg == 4'h7)
				begin
					rx_hold_reg <= '{data: {shift_reg[6:0], sda_sync[1]},
						first: first_reg};
					ev_tgl_reg.rx_byte <= !ev_tgl_reg.rx_byte;
				end
			end
			else if (scl_rise)
				lrb_reg <= sda_sync[1]; // [RQ6]
		end
	end

	// Master sequencer: start, eight data bits, released ACK slot, hold
	always_ff @(posedge link_clk_i)
	begin
		if (rst_l_sync[1] || !mst_l_sync[1])
		begin
			lstate_reg <= sbs_pkg::L_IDLE;
			scl_o <= 1'b0;
			sda_o <= 1'b0;
			scl_oe_n_o <= 1'b1;
			sda_oe_n_o <= 1'b1;
			div_reg <= 4'h0;
			mbit_reg <= 4'h0;
			mtx_reg <= 8'h00;
		end
		else if (!halt_l_sync[1])
		begin
			div_reg <= (div_reg == 4'h0) ? 4'h0 : div_reg - 4'h1;
			case (lstate_reg)
				sbs_pkg::L_IDLE:
					if (tx_req && !busy_reg)
					begin
						mtx_reg <= tx_data_reg;
						sda_oe_n_o <= 1'b0; // [RQ9]
						div_reg <= sbs_pkg::HALF_BIT_CYCLES;
						mbit_reg <= 4'h0;
						lstate_reg <= sbs_pkg::L_START;
					end
				sbs_pkg::L_START, sbs_pkg::L_HIGH:
					if (div_reg == 4'h0)
					begin
						scl_oe_n_o <= 1'b0;
						div_reg <= sbs_pkg::HALF_BIT_CYCLES;
						if (mbit_reg == sbs_pkg::BITS_PER_FRAME)
							lstate_reg <= sbs_pkg::L_HOLD;
						else
						begin
							sda_oe_n_o <= mbit_reg == 4'h8 || mtx_reg[7];
							mtx_reg <= {mtx_reg[6:0], 1'b0};
							lstate_reg <= sbs_pkg::L_LOW;
						end
					end
				sbs_pkg::L_LOW:
					if (div_reg == 4'h0)
					begin
						scl_oe_n_o <= 1'b1;
						mbit_reg <= mbit_reg + 4'h1;
						div_reg <= sbs_pkg::HALF_BIT_CYCLES;
						lstate_reg <= sbs_pkg::L_HIGH;
					end
				sbs_pkg::L_HOLD:
					if (tx_req)
					begin
						mtx_reg <= tx_data_reg; // [RQ8]
						mbit_reg <= 4'h0;
						div_reg <= 4'h0;
						lstate_reg <= sbs_pkg::L_HIGH;
					end
				default: lstate_reg <= sbs_pkg::L_IDLE;
			endcase
		end
	end

endmodule

// file: tb/sbs_bus_status_monitor.sv
// Port checker for the serial bus status block
`timescale 1ns/1ps
module sbs_bus_status_monitor #(
	parameter int ADDR_W = 8
)(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic scl_o,
	input wire logic sda_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	logic aw_w;
	logic ar_t;
	assign aw_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready;
	assign ar_t = s_axi_arvalid && s_axi_arready;
	a_bvalid_hold: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("bvalid dropped");
	a_rvalid_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("rvalid dropped");
	a_read_answer: assert property (
		ar_t |=> s_axi_rvalid) else $error("read late");
	a_write_answer: assert property (
		aw_w |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("bvalid late");
	a_ar_blocked: assert property (
		s_axi_rvalid |-> !s_axi_arready) else $error("arready in read");
	a_unmapped_read: assert property (
		ar_t && s_axi_araddr > sbs_pkg::OFF_BAUD_RATE_REG |=>
		s_axi_rresp == sbs_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read");
	a_status_ro: assert property (
		aw_w && s_axi_awaddr == sbs_pkg::OFF_BUS_STATUS_REG |=> ##1
		s_axi_bresp == sbs_pkg::RESP_SLVERR) else $error("status written");
	a_drive_low: assert property (
		scl_o == 1'b0 && sda_o == 1'b0) else $error("pin driven high");
	c_write: cover property (aw_w);
	c_read: cover property (ar_t);
	c_slverr: cover property (s_axi_bvalid
		&& s_axi_bresp == sbs_pkg::RESP_SLVERR);
endmodule

bind sbs_bus_status sbs_bus_status_monitor #(.ADDR_W(ADDR_W)) u_mon (
	.clk_i(clk_i), .reset_i(reset_i), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.scl_o(scl_o), .sda_o(sda_o));

// file: tb/sbs_i2c_agent.sv
// Open-drain bus master model that sends frames to the block
`timescale 1ns/1ps
module sbs_i2c_agent (
	input wire logic link_clk_i,
	output logic scl_oe_n_o,
	output logic sda_oe_n_o
);
	initial
	begin
		scl_oe_n_o = 1'b1;
		sda_oe_n_o = 1'b1;
	end
	task automatic wait_lk(input int n);
		repeat (n) @(posedge link_clk_i);
	endtask
	// SDA falls while SCL is high, then SCL goes low
	task automatic start_cond;
		wait_lk(1);
		sda_oe_n_o <= 1'b1;
		scl_oe_n_o <= 1'b1;
		wait_lk(4);
		sda_oe_n_o <= 1'b0;
		wait_lk(4);
		scl_oe_n_o <= 1'b0;
		wait_lk(4);
	endtask
	// Data set while SCL low, held through the high phase
	task automatic put_bit(input logic b);
		sda_oe_n_o <= b;
		wait_lk(4);
		scl_oe_n_o <= 1'b1;
		wait_lk(4);
		scl_oe_n_o <= 1'b0;
		wait_lk(4);
	endtask
	// Eight bits MSB first, then the acknowledge bit
	task automatic put_byte(input logic [7:0] d, input logic ack);
		for (int i = 7; i >= 0; i--)
			put_bit(d[i]);
		put_bit(ack);
	endtask
	task automatic stop_cond;
		wait_lk(1);
		sda_oe_n_o <= 1'b0;
		wait_lk(4);
		scl_oe_n_o <= 1'b1;
		wait_lk(4);
		sda_oe_n_o <= 1'b1;
		wait_lk(4);
	endtask
endmodule

// file: tb/tb.sv
// Self-checking bench for the serial bus status block
`timescale 1ns/1ps
module tb;
	logic clk_i = 0, link_clk_i = 0, reset_i = 1, idle_i = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, r;
	logic scl_o, sda_o, scl_oe_n, sda_oe_n, ag_scl_n, ag_sda_n;
	logic [31:0] d;
	logic [6:0] a;
	logic [7:0] fb;
	int miscompares = 0, checks = 0;
	wire scl = ag_scl_n & scl_oe_n;
	wire sda = ag_sda_n & sda_oe_n;
	always #5 clk_i = ~clk_i;
	always #62.5 link_clk_i = ~link_clk_i;
	sbs_bus_status dut (.clk_i(clk_i), .reset_i(reset_i),
		.link_clk_i(link_clk_i), .idle_i(idle_i), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .scl_i(scl), .sda_i(sda), .scl_o(scl_o),
		.scl_oe_n_o(scl_oe_n), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n));
	sbs_i2c_agent u_ag (.link_clk_i(link_clk_i),
		.scl_oe_n_o(ag_scl_n), .sda_oe_n_o(ag_sda_n));
	task end_of_test;
		if (miscompares == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task to_fail;
		miscompares++;
		$display("MISMATCH %0t wait ran out", $time);
		end_of_test;
	endtask
	task chk_reg(input logic [31:0] got, exp);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH %0t value %h exp %h", $time, got, exp);
		end
	endtask
	task chk_resp(input logic [1:0] got, exp);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH %0t resp %h exp %h", $time, got, exp);
		end
	endtask
	task axi_wr(input logic [7:0] ad, input logic [31:0] dt);
		int n;
		@(posedge clk_i);
		awaddr <= ad;
		wdata <= dt;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		for (n = 0; n < 200; n++)
		begin
			@(posedge clk_i);
			if (awvalid && awready)
				awvalid <= 0;
			if (wvalid && wready)
				wvalid <= 0;
			if (bvalid)
				break;
		end
		if (n == 200)
			to_fail;
		r = bresp;
		bready <= 0;
	endtask
	task axi_rd(input logic [7:0] ad);
		int n;
		@(posedge clk_i);
		araddr <= ad;
		arvalid <= 1;
		rready <= 1;
		for (n = 0; n < 200; n++)
		begin
			@(posedge clk_i);
			if (arvalid && arready)
				arvalid <= 0;
			if (rvalid)
				break;
		end
		if (n == 200)
			to_fail;
		d = rdata;
		r = rresp;
		rready <= 0;
	endtask
	task rd_chk(input logic [7:0] ad, input logic [31:0] m, exp);
		axi_rd(ad);
		chk_reg(d & m, exp);
		chk_resp(r, sbs_pkg::RESP_OKAY);
	endtask
	function logic [31:0] fl(input logic addressed_as_slave_flag, gc, last_received_bit);
		logic [31:0] f;
		f = 32'h0;
		f[sbs_pkg::SR_AAS] = addressed_as_slave_flag;
		f[sbs_pkg::SR_GC] = gc;
		f[sbs_pkg::SR_LRB] = last_received_bit;
		return f;
	endfunction
	function logic [31:0] cw(input logic [1:0] sw, input logic ms, md);
		logic [31:0] f;
		f = 32'h0;
		f[sbs_pkg::CR2_SOFT_RESET_FIELD_LO +: 2] = sw;
		f[sbs_pkg::CR2_MASTER] = ms;
		f[sbs_pkg::CR2_I2C_MODE] = md;
		return f;
	endfunction
	task frame(input logic [7:0] b, input logic ack);
		u_ag.start_cond;
		u_ag.put_byte(b, ack);
		repeat (80) @(posedge clk_i);
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(24));
		repeat (40) @(posedge clk_i);
		reset_i <= 0;
		for (int i = 0; i < 5; i++)
			rd_chk(8'(i * 4), i == 1 ? 32'h3 : 32'hFFFFFFFF, 0);
		axi_rd(8'h14);
		chk_resp(r, sbs_pkg::RESP_SLVERR);
		axi_wr(sbs_pkg::OFF_BUS_STATUS_REG, 32'hFF);
		chk_resp(r, sbs_pkg::RESP_SLVERR);
		axi_wr(sbs_pkg::OFF_CONTROL_REG_2, cw(0, 0, 1));
		for (int k = 0; k < 4; k++)
		begin
			a = 7'($urandom_range(2, 127));
			axi_wr(sbs_pkg::OFF_OWN_ADDRESS_REG, {a, 1'b0});
			fb = {k < 2 ? a : a ^ 7'h1, 1'($urandom)};
			frame(fb, k[0]);
			rd_chk(sbs_pkg::OFF_BUS_STATUS_REG, 32'h7, fl(k < 2, 0, k[0]));
			axi_rd(sbs_pkg::OFF_DATA_BUFFER_REG);
			chk_reg(d, {24'h0, fb});
			rd_chk(sbs_pkg::OFF_BUS_STATUS_REG, 32'h1, 0);
			u_ag.stop_cond;
		end
		frame(sbs_pkg::GEN_CALL_ADDR, 0);
		rd_chk(sbs_pkg::OFF_BUS_STATUS_REG, 32'h3, fl(1, 1, 0));
		u_ag.stop_cond;
		repeat (80) @(posedge clk_i);
		rd_chk(sbs_pkg::OFF_BUS_STATUS_REG, 32'h3, fl(1, 0, 0));
		axi_wr(sbs_pkg::OFF_DATA_BUFFER_REG, 32'($urandom_range(0, 255)));
		rd_chk(sbs_pkg::OFF_BUS_STATUS_REG, 32'h1, 0);
		axi_wr(sbs_pkg::OFF_OWN_ADDRESS_REG, 32'h1);
		frame(8'($urandom), 1);
		rd_chk(sbs_pkg::OFF_BUS_STATUS_REG, 32'h1, 0);
		u_ag.put_byte(8'($urandom), 1);
		repeat (80) @(posedge clk_i);
		rd_chk(sbs_pkg::OFF_BUS_STATUS_REG, 32'h1, 1);
		u_ag.stop_cond;
		axi_rd(sbs_pkg::OFF_DATA_BUFFER_REG);
		axi_wr(sbs_pkg::OFF_OWN_ADDRESS_REG, {a, 1'b0});
		idle_i <= 1;
		frame({a, 1'b0}, 1);
		rd_chk(sbs_pkg::OFF_BUS_STATUS_REG, 32'h1, 0);
		u_ag.stop_cond;
		idle_i <= 0;
		axi_wr(sbs_pkg::OFF_BAUD_RATE_REG, 32'h1);
		idle_i <= 1;
		frame({a, 1'b0}, 1);
		rd_chk(sbs_pkg::OFF_BUS_STATUS_REG, 32'h1, 1);
		u_ag.stop_cond;
		idle_i <= 0;
		axi_rd(sbs_pkg::OFF_DATA_BUFFER_REG);
		axi_wr(sbs_pkg::OFF_CONTROL_REG_2, cw(0, 1, 1));
		axi_wr(sbs_pkg::OFF_DATA_BUFFER_REG, {a, 1'b0});
		for (int n = 0; n <= 400; n++)
		begin
			@(posedge clk_i);
			if (sda_oe_n === 1'b0)
				break;
			if (n == 400)
				to_fail;
		end
		chk_reg(scl, 1);
		axi_wr(sbs_pkg::OFF_CONTROL_REG_2, cw(2, 0, 1));
		axi_wr(sbs_pkg::OFF_CONTROL_REG_2, cw(3, 0, 1));
		axi_wr(sbs_pkg::OFF_CONTROL_REG_2, cw(1, 0, 1));
		repeat (200) @(posedge clk_i);
		rd_chk(sbs_pkg::OFF_CONTROL_REG_2, 32'hFF, cw(1, 0, 1));
		rd_chk(sbs_pkg::OFF_OWN_ADDRESS_REG, 32'hFF, {a, 1'b0});
		axi_wr(sbs_pkg::OFF_CONTROL_REG_2, cw(2, 0, 1));
		axi_wr(sbs_pkg::OFF_CONTROL_REG_2, cw(1, 0, 1));
		repeat (200) @(posedge clk_i);
		rd_chk(sbs_pkg::OFF_CONTROL_REG_2, 32'hFF, 0);
		rd_chk(sbs_pkg::OFF_OWN_ADDRESS_REG, 32'hFF, 0);
		rd_chk(sbs_pkg::OFF_BAUD_RATE_REG, 32'hFF, 0);
		chk_reg(sda_oe_n, 1);
		end_of_test;
	end
endmodule
